// ### rtl/hwc_ctrl.sv
// Hart control: wait-for-interrupt stall, custom SYSTEM decode, reset state, NMI entry
`timescale 1ns/1ps
module hwc_ctrl #(
  parameter logic [31:0] RESET_VEC = hwc_pkg::RESET_VEC_DEF,
  parameter logic [31:0] NMI_VEC = hwc_pkg::NMI_VEC_DEF,
  parameter int NIRQ = hwc_pkg::NIRQ_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hwc_pkg::hwc_req_t req,
  input wire logic req_valid,
  input wire logic [NIRQ-1:0] irq_pending,
  input wire logic nmi_req,
  input wire logic [3:0] reset_cause,
  input wire logic resv_set,
  input wire logic resv_clear,
  output hwc_pkg::hwc_rsp_t rsp,
  output logic stall,
  output logic [1:0] privileged_minor_opcode_mode,
  output logic resv_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  hwc_pkg::hwc_state_t state_q, state_d;
  hwc_pkg::hwc_rsp_t rsp_q, rsp_d;
  logic [1:0] privileged_minor_opcode_q;
  logic sie_q, mie_q, modify_privilege_bit_q, tw_q, mbe_q;
  logic [NIRQ-1:0] irq_en_q, irq_deleg_q;
  logic [31:0] epc_q, cause_q, isa_q, tvec_q;
  logic [7:0] prot_q [hwc_pkg::PROT_ENTRIES];
  logic gmode_q, vsmode_q;
  logic nop_mode_q;
  logic [15:0] wait_limit_q, wait_cnt_q;
  logic [31:0] wfi_pc_q;
  logic nmi_prev_q, boot_q, stall_q, resv_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire in_run = (state_q == hwc_pkg::ST_RUN);
  wire in_wait = (state_q == hwc_pkg::ST_WAIT);
  wire nmi_edge = nmi_req & ~nmi_prev_q;
  wire [NIRQ-1:0] pend_en = irq_pending & irq_en_q;
  wire wake_any = |pend_en;
  wire glob_on = (privileged_minor_opcode_q != hwc_pkg::PRIVILEGED_MINOR_OPCODE_M) | mie_q;
  wire take_irq = wake_any & glob_on;
  wire is_wfi = req_valid & in_run & (req.word == hwc_pkg::WAIT_INSTR_WORD);
  wire [5:0] top_fn = req.word[31:26];
  wire is_cust = req_valid & in_run & (req.word[6:0] == hwc_pkg::OPC_SYSTEM) &
                 (req.word[14:12] == hwc_pkg::F3_PRIVILEGED_MINOR_OPCODE) &
                 ((top_fn & hwc_pkg::CUST_MASK) == hwc_pkg::CUST_MATCH);
  wire [1:0] cust_privileged_minor_opcode = req.word[29:28];
  wire cust_bad = (privileged_minor_opcode_q < cust_privileged_minor_opcode);
  wire wfi_bad = tw_q & (privileged_minor_opcode_q != hwc_pkg::PRIVILEGED_MINOR_OPCODE_M);
  wire timeout_hit = in_wait & (wait_limit_q != hwc_pkg::WAIT_LIMIT_RST) &
                     (wait_cnt_q == wait_limit_q);

  wire ev_wfi_ill = ~nmi_edge & is_wfi & wfi_bad;
  wire ev_wfi_nop = ~nmi_edge & is_wfi & ~wfi_bad & nop_mode_q;
  wire ev_wfi_now = ~nmi_edge & is_wfi & ~wfi_bad & ~nop_mode_q & wake_any;
  wire ev_wfi_stall = ~nmi_edge & is_wfi & ~wfi_bad & ~nop_mode_q & ~wake_any;
  wire ev_wake = ~nmi_edge & in_wait & wake_any;
  wire ev_tmo = ~nmi_edge & in_wait & ~wake_any & timeout_hit;
  wire ev_cust = ~nmi_edge & is_cust;
  wire ev_resume = ev_wfi_now | ev_wake;
  wire ev_irq_trap = ev_resume & take_irq;
  wire ev_ill_trap = ev_wfi_ill | (ev_cust & cust_bad) | ev_tmo;
  wire ev_trap = ev_irq_trap | ev_ill_trap;
  wire ev_done = ev_wfi_ill | ev_wfi_nop | ev_resume | ev_tmo | ev_cust;
  wire [31:0] instr_pc = in_wait ? wfi_pc_q : req.pc;
  wire [31:0] next_pc = instr_pc + hwc_pkg::PC_STEP;
  wire [31:0] nmi_pc = in_wait ? next_pc : req.pc;

  // Lowest numbered enabled pending interrupt gives the cause code
  logic [31:0] irq_cause;
  always_comb begin
    irq_cause = hwc_pkg::CAUSE_NMI;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (pend_en[i]) begin
        irq_cause = hwc_pkg::CAUSE_NMI | 32'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hwc_pkg::ST_RUN: begin
        if (ev_wfi_stall) begin
          state_d = hwc_pkg::ST_WAIT;
        end
      end
      hwc_pkg::ST_WAIT: begin
        if (nmi_edge | ev_wake | ev_tmo) begin
          state_d = hwc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_comb begin
    rsp_d = '0;
    rsp_d.done = ev_done;
    rsp_d.illegal = ev_ill_trap;
    rsp_d.custom_hit = ev_cust;
    rsp_d.custom_privileged_minor_opcode = cust_privileged_minor_opcode;
    rsp_d.redirect = ev_done | nmi_edge;
    if (nmi_edge) begin
      rsp_d.redirect_pc = NMI_VEC;
    end else if (ev_trap) begin
      rsp_d.redirect_pc = tvec_q;
    end else begin
      rsp_d.redirect_pc = next_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= hwc_pkg::ST_RUN;
      stall_q <= 1'b0;
      rsp_q <= '{default: '0, redirect: 1'b1, redirect_pc: RESET_VEC};
      wfi_pc_q <= '0;
      wait_cnt_q <= '0;
      nmi_prev_q <= 1'b0;
      boot_q <= 1'b1;
    end else begin
      state_q <= state_d;
      stall_q <= (state_d == hwc_pkg::ST_WAIT);
      rsp_q <= rsp_d;
      wfi_pc_q <= ev_wfi_stall ? req.pc : wfi_pc_q;
      wait_cnt_q <= in_wait ? wait_cnt_q + 16'h0001 : 16'h0000;
      nmi_prev_q <= nmi_req;
      boot_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  wire apb_setup = psel & penable & ~pready_q;
  wire apb_wr = psel & penable & pready_q & pwrite;
  wire sel_status = (paddr == hwc_pkg::REG_STATUS);
  wire sel_statush = (paddr == hwc_pkg::REG_STATUSH);
  wire sel_irq_en = (paddr == hwc_pkg::REG_IRQ_EN);
  wire sel_deleg = (paddr == hwc_pkg::REG_IRQ_DELEG);
  wire sel_epc = (paddr == hwc_pkg::REG_EPC);
  wire sel_cause = (paddr == hwc_pkg::REG_CAUSE);
  wire sel_isa = (paddr == hwc_pkg::REG_ISA);
  wire sel_hart = (paddr == hwc_pkg::REG_HART);
  wire sel_wcfg = (paddr == hwc_pkg::REG_WAIT_CFG);
  wire sel_tvec = (paddr == hwc_pkg::REG_TVEC);
  wire sel_prot = (paddr == hwc_pkg::REG_PROT);
  wire sel_gmode = (paddr == hwc_pkg::REG_GMODE);
  wire addr_hit = sel_status | sel_statush | sel_irq_en | sel_deleg | sel_epc | sel_cause |
                  sel_isa | sel_hart | sel_wcfg | sel_tvec | sel_prot | sel_gmode;

  wire [31:0] rd_status = (32'(tw_q) << hwc_pkg::ST_TW_BIT) | (32'(modify_privilege_bit_q) << hwc_pkg::ST_MODIFY_PRIVILEGE_BIT_BIT) |
                          (32'(mie_q) << hwc_pkg::ST_MIE_BIT) | (32'(sie_q) << hwc_pkg::ST_SIE_BIT);
  wire [31:0] rd_hart = (32'(resv_q) << hwc_pkg::HART_RESV_BIT) |
                        (32'(stall_q) << hwc_pkg::HART_STALL_BIT) | 32'(privileged_minor_opcode_q);
  wire [31:0] rd_prot = {prot_q[3], prot_q[2], prot_q[1], prot_q[0]};
  wire [31:0] rd_val =
    sel_status ? rd_status :
    sel_statush ? (32'(mbe_q) << hwc_pkg::STH_MBE_BIT) :
    sel_irq_en ? 32'(irq_en_q) :
    sel_deleg ? 32'(irq_deleg_q) :
    sel_epc ? epc_q :
    sel_cause ? cause_q :
    sel_isa ? isa_q :
    sel_hart ? rd_hart :
    sel_wcfg ? ((32'(nop_mode_q) << hwc_pkg::WCFG_NOP_BIT) | 32'(wait_limit_q)) :
    sel_tvec ? tvec_q :
    sel_prot ? rd_prot :
    sel_gmode ? {30'h0, vsmode_q, gmode_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~addr_hit;
      prdata_q <= apb_setup ? rd_val : prdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state; hardware events win over software writes
  wire [1:0] wr_privileged_minor_opcode = pwdata[1:0];
  wire privileged_minor_opcode_legal = (wr_privileged_minor_opcode != hwc_pkg::PRIVILEGED_MINOR_OPCODE_H);
  wire [31:0] isa_wr = (pwdata & hwc_pkg::ISA_MAX & ~hwc_pkg::ISA_MXL_MASK) |
                       hwc_pkg::ISA_MXL_MASK & hwc_pkg::ISA_MAX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      privileged_minor_opcode_q <= hwc_pkg::PRIVILEGED_MINOR_OPCODE_M;
      epc_q <= '0;
      cause_q <= hwc_pkg::CAUSE_RST;
    end else if (nmi_edge) begin
      privileged_minor_opcode_q <= hwc_pkg::PRIVILEGED_MINOR_OPCODE_M;
      epc_q <= nmi_pc;
      cause_q <= hwc_pkg::CAUSE_NMI;
    end else if (ev_trap) begin
      privileged_minor_opcode_q <= hwc_pkg::PRIVILEGED_MINOR_OPCODE_M;
      epc_q <= ev_irq_trap ? next_pc : instr_pc;
      cause_q <= ev_irq_trap ? irq_cause : hwc_pkg::CAUSE_ILLEGAL;
    end else begin
      if (boot_q) begin
        cause_q <= 32'(reset_cause);
      end else if (apb_wr & sel_cause) begin
        cause_q <= pwdata;
      end
      if (apb_wr & sel_epc) begin
        epc_q <= {pwdata[31:2], 2'b00};
      end
      if (apb_wr & sel_hart & privileged_minor_opcode_legal) begin
        privileged_minor_opcode_q <= wr_privileged_minor_opcode;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mie_q <= 1'b0;
      modify_privilege_bit_q <= 1'b0;
      mbe_q <= 1'b0;
      sie_q <= 1'b0;
      tw_q <= 1'b0;
      isa_q <= hwc_pkg::ISA_MAX;
      gmode_q <= 1'b0;
      vsmode_q <= 1'b0;
      irq_en_q <= '0;
      irq_deleg_q <= '0;
      tvec_q <= hwc_pkg::TVEC_RST;
      nop_mode_q <= 1'b0;
      wait_limit_q <= hwc_pkg::WAIT_LIMIT_RST;
    end else if (apb_wr) begin
      if (sel_status) begin
        mie_q <= pwdata[hwc_pkg::ST_MIE_BIT];
        sie_q <= pwdata[hwc_pkg::ST_SIE_BIT];
        modify_privilege_bit_q <= pwdata[hwc_pkg::ST_MODIFY_PRIVILEGE_BIT_BIT];
        tw_q <= pwdata[hwc_pkg::ST_TW_BIT];
      end
      if (sel_statush) begin
        mbe_q <= pwdata[hwc_pkg::STH_MBE_BIT];
      end
      if (sel_isa) begin
        isa_q <= isa_wr;
      end
      if (sel_gmode) begin
        gmode_q <= pwdata[0];
        vsmode_q <= pwdata[1];
      end
      if (sel_irq_en) begin
        irq_en_q <= pwdata[NIRQ-1:0];
      end
      if (sel_deleg) begin
        irq_deleg_q <= pwdata[NIRQ-1:0];
      end
      if (sel_tvec) begin
        tvec_q <= {pwdata[31:2], 2'b00};
      end
      if (sel_wcfg) begin
        nop_mode_q <= pwdata[hwc_pkg::WCFG_NOP_BIT];
        wait_limit_q <= pwdata[15:0];
      end
    end
  end

  // Protection entries; a locked entry ignores writes
  for (genvar g = 0; g < hwc_pkg::PROT_ENTRIES; g++) begin : g_prot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prot_q[g] <= 8'h00;
      end else if (apb_wr & sel_prot & ~prot_q[g][hwc_pkg::PROT_L_BIT]) begin
        prot_q[g] <= pwdata[g*8 +: 8] & hwc_pkg::PROT_AL_MASK;
      end
    end
  end

  // Reservation: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resv_q <= 1'b0;
    end else if (resv_set) begin
      resv_q <= 1'b1;
    end else if (resv_clear) begin
      resv_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rsp = rsp_q;
  assign stall = stall_q;
  assign privileged_minor_opcode_mode = privileged_minor_opcode_q;
  assign resv_valid = resv_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_boot_state: assert property (boot_q |-> privileged_minor_opcode_q == hwc_pkg::PRIVILEGED_MINOR_OPCODE_M && !mie_q && !modify_privilege_bit_q &&
                                 rsp_q.redirect_pc == RESET_VEC && !resv_q && isa_q == hwc_pkg::ISA_MAX)
    else $error("Reset state wrong");
  a_wfi_tw_trap: assert property (ev_wfi_ill |=> rsp_q.illegal && cause_q == hwc_pkg::CAUSE_ILLEGAL)
    else $error("Wait under trap bit not illegal");
  a_wake_trap_epc: assert property (in_wait && ev_irq_trap |=> epc_q == $past(wfi_pc_q) + 32'h4
                                    && rsp_q.redirect_pc == tvec_q)
    else $error("Wake trap epc wrong");
  a_wfi_nop_path: assert property (ev_wfi_nop |=> !stall_q && rsp_q.done
                                   && rsp_q.redirect_pc == $past(req.pc) + 32'h4)
    else $error("No-op wait stalled");
  a_wake_global_off: assert property (in_wait && wake_any && !mie_q && !nmi_edge |=> !stall_q)
    else $error("Wake blocked by global enable");
  a_stay_stalled: assert property (in_wait && !(|(irq_pending & irq_en_q)) && !nmi_edge
                                   && !timeout_hit |=> stall_q)
    else $error("Woke without enabled interrupt");
  a_resume_pc: assert property (ev_wake && !take_irq |=> rsp_q.redirect_pc == $past(wfi_pc_q) + 32'h4)
    else $error("Resume pc wrong");
  a_wait_timeout: assert property (ev_tmo |=> privileged_minor_opcode_q == hwc_pkg::PRIVILEGED_MINOR_OPCODE_M && rsp_q.illegal
                                   && epc_q == $past(wfi_pc_q))
    else $error("Timeout trap wrong");
  a_custom_decode: assert property (ev_cust |=> rsp_q.custom_hit && rsp_q.custom_privileged_minor_opcode == $past(req.word[29:28]))
    else $error("Custom decode wrong");
  a_nmi_entry: assert property (nmi_edge |=> privileged_minor_opcode_q == hwc_pkg::PRIVILEGED_MINOR_OPCODE_M && cause_q == hwc_pkg::CAUSE_NMI
                                && rsp_q.redirect_pc == NMI_VEC && epc_q == $past(nmi_pc) && !stall_q)
    else $error("NMI entry wrong");
  a_nmi_keeps: assert property (nmi_edge && !apb_wr |=> $stable(mie_q) && $stable(irq_en_q)
                                && $stable(isa_q) && $stable(tvec_q))
    else $error("NMI disturbed state");

  c_wait_wake: cover property (ev_wfi_stall ##[1:20] ev_wake);
  c_nmi_in_wait: cover property (in_wait && nmi_edge);
  c_custom_bad: cover property (ev_cust && cust_bad);

endmodule : hwc_ctrl

// ### include/hwc_pkg.sv
// Shared constants and types for the hart wait, reset and NMI controller
package hwc_pkg;

  localparam int NIRQ_DEF = 16;
  localparam int PROT_ENTRIES = 4;

  // Privilege encodings
  localparam logic [1:0] PRIVILEGED_MINOR_OPCODE_U = 2'h0;
  localparam logic [1:0] PRIVILEGED_MINOR_OPCODE_S = 2'h1;
  localparam logic [1:0] PRIVILEGED_MINOR_OPCODE_H = 2'h2;
  localparam logic [1:0] PRIVILEGED_MINOR_OPCODE_M = 2'h3;

  // Instruction decode
  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [2:0] F3_PRIVILEGED_MINOR_OPCODE = 3'h0;
  localparam logic [31:0] WAIT_INSTR_WORD = 32'h10500073;
  // Custom SYSTEM space: top_function_field matches 1x??11
  localparam logic [5:0] CUST_MASK = 6'h23;
  localparam logic [5:0] CUST_MATCH = 6'h23;
  localparam logic [31:0] PC_STEP = 32'h00000004;

  // Register offsets (byte addresses)
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_STATUSH = 12'h004;
  localparam logic [11:0] REG_IRQ_EN = 12'h008;
  localparam logic [11:0] REG_IRQ_DELEG = 12'h00C;
  localparam logic [11:0] REG_EPC = 12'h010;
  localparam logic [11:0] REG_CAUSE = 12'h014;
  localparam logic [11:0] REG_ISA = 12'h018;
  localparam logic [11:0] REG_HART = 12'h01C;
  localparam logic [11:0] REG_WAIT_CFG = 12'h020;
  localparam logic [11:0] REG_TVEC = 12'h024;
  localparam logic [11:0] REG_PROT = 12'h028;
  localparam logic [11:0] REG_GMODE = 12'h02C;

  // Field positions
  localparam int ST_SIE_BIT = 1;
  localparam int ST_MIE_BIT = 3;
  localparam int ST_MODIFY_PRIVILEGE_BIT_BIT = 17;
  localparam int ST_TW_BIT = 21;
  localparam int STH_MBE_BIT = 5;
  localparam int HART_STALL_BIT = 2;
  localparam int HART_RESV_BIT = 3;
  localparam int WCFG_NOP_BIT = 16;
  localparam int PROT_L_BIT = 7;
  localparam logic [7:0] PROT_AL_MASK = 8'h98;

  // Reset values
  localparam logic [31:0] RESET_VEC_DEF = 32'h00001000;
  localparam logic [31:0] NMI_VEC_DEF = 32'h00000100;
  localparam logic [31:0] TVEC_RST = 32'h00000000;
  // MXL=32-bit, extensions A H I M S U
  localparam logic [31:0] ISA_MAX = 32'h40141181;
  localparam logic [31:0] ISA_MXL_MASK = 32'hC0000000;
  localparam logic [31:0] CAUSE_RST = 32'h00000000;
  localparam logic [31:0] CAUSE_ILLEGAL = 32'h00000002;
  localparam logic [31:0] CAUSE_NMI = 32'h80000000;
  localparam logic [15:0] WAIT_LIMIT_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WAIT = 2'b10
  } hwc_state_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] word;
  } hwc_req_t;

  typedef struct packed {
    logic done;
    logic illegal;
    logic custom_hit;
    logic [1:0] custom_privileged_minor_opcode;
    logic redirect;
    logic [31:0] redirect_pc;
  } hwc_rsp_t;

endpackage : hwc_pkg

// ### test/hwc_plat_model.sv
// Platform model: interrupt lines, NMI generator and reset cause source
`timescale 1ns/1ps
module hwc_plat_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] irq_want,
  input wire logic [3:0] lag,
  input wire logic nmi_go,
  input wire logic [3:0] cause_in,
  output logic [15:0] irq_pending,
  output logic nmi_req,
  output logic [3:0] reset_cause
);
  logic [3:0] cnt_q;
  logic [1:0] nmi_q;

  assign nmi_req = |nmi_q;
  assign reset_cause = cause_in;

  ////////////////////////////////////////////////////////////////////////////
  // Pending lines follow the request lag+1 cycles after it changes, held as levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pending <= 16'h0000;
      cnt_q <= 4'h0;
    end else if (irq_want != irq_pending) begin
      if (cnt_q >= lag) begin
        irq_pending <= irq_want;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end

  // Error source: level held three cycles per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_q <= 2'h0;
    end else if (nmi_go) begin
      nmi_q <= 2'h3;
    end else if (nmi_q != 2'h0) begin
      nmi_q <= nmi_q - 2'h1;
    end
  end
endmodule : hwc_plat_model

// ### test/hwc_ctrl_tb.sv
// Self-checking bench for the hart wait, reset and NMI controller
`timescale 1ns/1ps
module hwc_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, nmi_req;
  logic resv_set, resv_clear, stall, resv_valid, nmi_go, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pc, w, r;
  logic [15:0] irq_pending, irq_want;
  logic [3:0] lag, cause_in, reset_cause;
  logic [1:0] privileged_minor_opcode_mode, cur;
  hwc_pkg::hwc_req_t req;
  hwc_pkg::hwc_rsp_t rsp, ev_rsp;
  logic [5:0] cust_f6 [8] = '{6'h23, 6'h33, 6'h27, 6'h37, 6'h2B, 6'h3B, 6'h2F, 6'h3F};
  int mismatches = 0;
  int compares = 0;
  int ev_cnt = 0;
  int seed, k, j, s, p;

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  hwc_ctrl i_hwc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .req_valid(req_valid), .irq_pending(irq_pending), .nmi_req(nmi_req), .reset_cause(reset_cause),
    .resv_set(resv_set), .resv_clear(resv_clear), .rsp(rsp), .stall(stall), .privileged_minor_opcode_mode(privileged_minor_opcode_mode),
    .resv_valid(resv_valid));

  hwc_plat_model i_hwc_plat_model (.pclk(pclk), .presetn(presetn), .irq_want(irq_want), .lag(lag),
    .nmi_go(nmi_go), .cause_in(cause_in), .irq_pending(irq_pending), .nmi_req(nmi_req),
    .reset_cause(reset_cause));

  // Capture each one-cycle response pulse
  always @(posedge pclk) begin
    if (rsp.done === 1'b1 || rsp.redirect === 1'b1) begin
      ev_rsp <= rsp;
      ev_cnt <= ev_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] rpc();
    return $random(seed) & 32'hFFFFFFFC;
  endfunction : rpc

  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      finish_test();
    end
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, rd, err);
    chk(rd & m, e);
  endtask : rdc

  task go(input logic [31:0] a, input logic [31:0] wd);
    s = ev_cnt;
    req <= '{pc: a, word: wd};
    req_valid <= 1'b1;
    @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
  endtask : go

  task wait_ev;
    int n;
    n = 0;
    while (ev_cnt == s && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (ev_cnt == s) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_ev

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 53379;
    {presetn, psel, penable, pwrite, req_valid, resv_set, resv_clear, nmi_go} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    req = '0;
    irq_want = 16'h0000;
    lag = 4'h0;
    cause_in = 4'h0;
    repeat (10) @(posedge pclk);
    chk(rsp.redirect_pc, hwc_pkg::RESET_VEC_DEF);
    chk(32'(privileged_minor_opcode_mode), 32'h00000003);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(hwc_pkg::REG_STATUS, 32'h00020008, 32'h00000000);
    rdc(hwc_pkg::REG_STATUSH, 32'h00000020, 32'h00000000);
    rdc(hwc_pkg::REG_ISA, 32'hFFFFFFFF, hwc_pkg::ISA_MAX);
    rdc(hwc_pkg::REG_HART, 32'h0000000F, 32'h00000003);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, hwc_pkg::CAUSE_RST);
    rdc(hwc_pkg::REG_PROT, 32'h98989898, 32'h00000000);
    rdc(hwc_pkg::REG_GMODE, 32'h00000003, 32'h00000000);
    apb(1'b0, 12'h030, 32'h00000000, rd, err);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    wr(hwc_pkg::REG_ISA, 32'hFFFFFFFF);
    rdc(hwc_pkg::REG_ISA, hwc_pkg::ISA_MXL_MASK, hwc_pkg::ISA_MAX & hwc_pkg::ISA_MXL_MASK);
    wr(hwc_pkg::REG_HART, 32'h00000002);
    rdc(hwc_pkg::REG_HART, 32'h00000003, 32'h00000003);
    // Every custom pattern from user and machine level
    for (p = 0; p < 2; p++) begin
      cur = (p == 0) ? hwc_pkg::PRIVILEGED_MINOR_OPCODE_U : hwc_pkg::PRIVILEGED_MINOR_OPCODE_M;
      for (k = 0; k < 8; k++) begin
        wr(hwc_pkg::REG_HART, {30'h0, cur});
        r = $random(seed);
        w = {cust_f6[k], r[25:15], 3'h0, r[11:7], 7'h73};
        go(rpc(), w);
        wait_ev();
        chk({ev_rsp.done, ev_rsp.custom_hit, ev_rsp.custom_privileged_minor_opcode}, {2'b11, w[29:28]});
        chk(32'(ev_rsp.illegal), 32'(w[29:28] > cur));
      end
    end
    // Wake with global enables off and full delegation
    wr(hwc_pkg::REG_HART, 32'h00000003);
    wr(hwc_pkg::REG_IRQ_DELEG, 32'h0000FFFF);
    k = $unsigned($random(seed)) % 16;
    j = (k + 1) % 16;
    wr(hwc_pkg::REG_IRQ_EN, 32'h00000001 << k);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    chk(32'(stall), 32'h00000001);
    irq_want <= 16'h0001 << j;
    lag <= 4'h3;
    repeat (12) @(posedge pclk);
    chk(32'(stall), 32'h00000001);
    irq_want <= (16'h0001 << j) | (16'h0001 << k);
    wait_ev();
    chk(ev_rsp.redirect_pc, pc + hwc_pkg::PC_STEP);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, hwc_pkg::CAUSE_ILLEGAL);
    // Enabled interrupt with global enable set
    irq_want <= 16'h0001 << k;
    lag <= 4'h0;
    wr(hwc_pkg::REG_TVEC, 32'h00000200);
    wr(hwc_pkg::REG_STATUS, 32'h00000008);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    wait_ev();
    chk(ev_rsp.redirect_pc, 32'h00000200);
    rdc(hwc_pkg::REG_EPC, 32'hFFFFFFFF, pc + hwc_pkg::PC_STEP);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, 32'h80000000 | k);
    irq_want <= 16'h0000;
    // Enabled interrupt arriving during a stall from user level
    wr(hwc_pkg::REG_HART, 32'h00000000);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    irq_want <= 16'h0001 << k;
    wait_ev();
    chk(ev_rsp.redirect_pc, 32'h00000200);
    rdc(hwc_pkg::REG_EPC, 32'hFFFFFFFF, pc + hwc_pkg::PC_STEP);
    irq_want <= 16'h0000;
    wr(hwc_pkg::REG_IRQ_EN, 32'h00000000);
    // Wait trap bit from user level
    wr(hwc_pkg::REG_HART, 32'h00000000);
    wr(hwc_pkg::REG_STATUS, 32'h00200000);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    wait_ev();
    chk(32'(ev_rsp.illegal), 32'h00000001);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, hwc_pkg::CAUSE_ILLEGAL);
    rdc(hwc_pkg::REG_EPC, 32'hFFFFFFFF, pc);
    // Stall limit and plain no-op modes
    wr(hwc_pkg::REG_STATUS, 32'h00000000);
    wr(hwc_pkg::REG_WAIT_CFG, 32'h00000005);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    wait_ev();
    chk(ev_rsp.redirect_pc, 32'h00000200);
    rdc(hwc_pkg::REG_EPC, 32'hFFFFFFFF, pc);
    wr(hwc_pkg::REG_WAIT_CFG, 32'h00010000);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    chk(32'(stall), 32'h00000000);
    wait_ev();
    chk(ev_rsp.redirect_pc, pc + hwc_pkg::PC_STEP);
    // Error interrupt during a stall from user level
    wr(hwc_pkg::REG_WAIT_CFG, 32'h00000000);
    wr(hwc_pkg::REG_STATUS, 32'h00000008);
    wr(hwc_pkg::REG_HART, 32'h00000000);
    pc = rpc();
    go(pc, hwc_pkg::WAIT_INSTR_WORD);
    nmi_go <= 1'b1;
    @(posedge pclk);
    nmi_go <= 1'b0;
    wait_ev();
    chk(ev_rsp.redirect_pc, hwc_pkg::NMI_VEC_DEF);
    chk({29'h0, stall, privileged_minor_opcode_mode}, 32'h00000003);
    rdc(hwc_pkg::REG_EPC, 32'hFFFFFFFF, pc + hwc_pkg::PC_STEP);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, hwc_pkg::CAUSE_NMI);
    rdc(hwc_pkg::REG_STATUS, 32'hFFFFFFFF, 32'h00000008);
    // Second reset with a reservation held
    {resv_set, resv_clear} <= 2'b11;
    @(posedge pclk);
    {resv_set, resv_clear} <= 2'b00;
    @(posedge pclk);
    chk(32'(resv_valid), 32'h00000001);
    cause_in <= 4'h3;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({29'h0, resv_valid, privileged_minor_opcode_mode}, 32'h00000003);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(hwc_pkg::REG_CAUSE, 32'hFFFFFFFF, 32'h00000003);
    rdc(hwc_pkg::REG_STATUS, 32'h00020008, 32'h00000000);
    finish_test();
  end
endmodule : hwc_ctrl_tb
